// ===== tmr0_pkg.sv
// package of constants for the timer 0 counting block
// assumes one clock and the plain register port of tmr0_top
package tmr0_pkg;

  // ==========================================================
  // register addresses (8-bit register port)
  localparam logic [7:0] ADDR_FLAGS  = 8'hD8;
  localparam logic [7:0] ADDR_MODE   = 8'hDA;
  localparam logic [7:0] ADDR_COUNT  = 8'hDB;
  localparam logic [7:0] ADDR_RELOAD = 8'hCD;

  // ==========================================================
  // mode register fields
  localparam int MODE_PWM_BIT    = 0;
  localparam int MODE_TONE_BIT   = 1;
  localparam int MODE_RELOAD_BIT = 2;
  localparam int MODE_RATE_LSB   = 4;
  localparam int MODE_ENABLE_BIT = 7;
  // flags register field
  localparam int FLAGS_FAST_BIT  = 2;

  // ==========================================================
  // reset values
  localparam logic [7:0] MODE_RESET   = 8'h00;
  localparam logic [7:0] FLAGS_RESET  = 8'h00;
  localparam logic [7:0] COUNT_RESET  = 8'h00;
  localparam logic [7:0] RELOAD_RESET = 8'h00;
  localparam logic       TONE_RESET   = 1'b0;

  // ==========================================================
  // counter boundaries
  localparam logic [7:0] BOUND_FULL   = 8'hFF;
  localparam logic [7:0] BOUND_PWM_HI = 8'h7F;
  localparam logic [7:0] WRAP_VALUE   = 8'h00;

  // ==========================================================
  // prescaler: log2 of division for rate code 000
  localparam logic [3:0] CPU_LOG2_BASE = 4'h8;
  localparam logic [3:0] OSC_LOG2_BASE = 4'h7;
  // cpu clock divider from the oscillator (mclk) clock
  localparam int CPU_DIV_DEFAULT = 4;

endpackage

// ===== tmr0_presc_if.sv
// carrier between the timer top and its prescaler
// assumes both ends share mclk_in
`timescale 1ns/1ps
`default_nettype none
interface tmr0_presc_if;
  logic       enable;
  logic       fast;
  logic [2:0] rate;
  logic       tick;

  modport ctrl  (output enable, output fast, output rate, input tick);
  modport presc (input enable, input fast, input rate, output tick);
endinterface
`default_nettype wire

// ===== tmr0_presc.sv
// prescaler: cpu-rate divider plus selectable power-of-two divider
// assumes mclk_in is the oscillator clock, synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module tmr0_presc #(
  parameter int CPU_DIV = tmr0_pkg::CPU_DIV_DEFAULT
) (
  input  wire logic   mclk_in,
  input  wire logic   resetn_in,
  tmr0_presc_if.presc pif
);
  localparam int CW = (CPU_DIV > 1) ? $clog2(CPU_DIV) : 1;

  if (CPU_DIV < 1)
  begin : g_chk
    $error("CPU_DIV must be at least 1");
  end

  logic [CW-1:0] cpu_cnt_reg;
  logic          cpu_en;
  logic [7:0]    pre_cnt_reg;
  logic [3:0]    log2_div;
  logic [7:0]    mask;
  logic          src_en;

  // ==========================================================
  // cpu clock enable, free running
  assign cpu_en = (cpu_cnt_reg == CW'(CPU_DIV - 1));

  always_ff @(posedge mclk_in)
  begin
    if (!resetn_in)
      cpu_cnt_reg <= '0;
    else if (cpu_en)
      cpu_cnt_reg <= '0;
    else
      cpu_cnt_reg <= cpu_cnt_reg + CW'(1);
  end

  // ==========================================================
  // source select and division
  assign src_en   = pif.fast ? 1'b1 : cpu_en;
  assign log2_div = (pif.fast ? tmr0_pkg::OSC_LOG2_BASE
                              : tmr0_pkg::CPU_LOG2_BASE)
                    - {1'b0, pif.rate};
  assign mask     = 8'((9'h001 << log2_div) - 9'h001);

  always_ff @(posedge mclk_in)
  begin
    if (!resetn_in || !pif.enable)
      pre_cnt_reg <= 8'h00;
    else if (src_en)
      pre_cnt_reg <= pre_cnt_reg + 8'h01;
  end

  assign pif.tick = pif.enable && src_en && ((pre_cnt_reg & mask) == mask);
endmodule
`default_nettype wire

// ===== tmr0_top.sv
// timer 0 counting block: counter, reload, prescaler, tone output
// assumes one clock mclk_in (oscillator rate), plain register port
//
// Added by the designer: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module tmr0_top #(
  parameter int CPU_DIV = tmr0_pkg::CPU_DIV_DEFAULT
) (
  input  wire logic       mclk_in,
  input  wire logic       resetn_in,
  input  wire logic [7:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output logic      [7:0] rdata_out,
  output logic            timeout_out,
  output logic            tone_pin_out,
  output logic            tone_pin_oe_out,
  output logic            gpio_disable_out
);
  logic [7:0] mode_reg;
  logic [7:0] flags_reg;
  logic [7:0] count_reg;
  logic [7:0] reload_reg;
  logic       tone_reg;
  logic [7:0] rdata_reg;
  logic       timeout_reg;
  logic [7:0] count_next;
  logic [7:0] bound;
  logic       pwm_on;
  logic       reload_on;
  logic       tone_on;
  logic       ovf;

  tmr0_presc_if pif ();

  tmr0_presc #(
    .CPU_DIV   (CPU_DIV)
  ) u_presc (
    .mclk_in   (mclk_in),
    .resetn_in (resetn_in),
    .pif       (pif)
  );

  // ==========================================================
  // mode decode
  assign pwm_on      = mode_reg[tmr0_pkg::MODE_PWM_BIT];
  assign reload_on   = pwm_on | mode_reg[tmr0_pkg::MODE_RELOAD_BIT];
  assign tone_on     = mode_reg[tmr0_pkg::MODE_TONE_BIT] & ~pwm_on;
  assign bound       = (pwm_on && mode_reg[tmr0_pkg::MODE_RELOAD_BIT])
                       ? tmr0_pkg::BOUND_PWM_HI : tmr0_pkg::BOUND_FULL;
  assign pif.enable  = mode_reg[tmr0_pkg::MODE_ENABLE_BIT];
  assign pif.fast    = flags_reg[tmr0_pkg::FLAGS_FAST_BIT];
  assign pif.rate    = mode_reg[tmr0_pkg::MODE_RATE_LSB +: 3];

  wire count_wr = wr_in && (addr_in == tmr0_pkg::ADDR_COUNT);

  // ==========================================================
  // configuration registers
  always_ff @(posedge mclk_in)
  begin
    if (!resetn_in)
      mode_reg <= tmr0_pkg::MODE_RESET;
    else if (wr_in && addr_in == tmr0_pkg::ADDR_MODE)
      mode_reg <= wdata_in & 8'hF7;
  end

  always_ff @(posedge mclk_in)
  begin
    if (!resetn_in)
      flags_reg <= tmr0_pkg::FLAGS_RESET;
    else if (wr_in && addr_in == tmr0_pkg::ADDR_FLAGS)
      flags_reg <= wdata_in & 8'h04;
  end

  always_ff @(posedge mclk_in)
  begin
    if (!resetn_in)
      reload_reg <= tmr0_pkg::RELOAD_RESET;
    else if (wr_in && addr_in == tmr0_pkg::ADDR_RELOAD)
      reload_reg <= wdata_in;
  end

  // ==========================================================
  // counter
  assign ovf = pif.tick && (count_reg == bound) && !count_wr;

  always_comb
  begin
    count_next = count_reg;
    if (count_wr)
      count_next = wdata_in;
    else if (ovf)
      count_next = reload_on ? reload_reg : tmr0_pkg::WRAP_VALUE;
    else if (pif.tick)
      count_next = count_reg + 8'h01;
  end

  always_ff @(posedge mclk_in)
  begin
    if (!resetn_in)
      count_reg <= tmr0_pkg::COUNT_RESET;
    else
      count_reg <= count_next;
  end

  always_ff @(posedge mclk_in)
  begin
    if (!resetn_in)
      timeout_reg <= 1'b0;
    else
      timeout_reg <= ovf;
  end

  // ==========================================================
  // tone output
  always_ff @(posedge mclk_in)
  begin
    if (!resetn_in)
      tone_reg <= tmr0_pkg::TONE_RESET;
    else if (ovf)
      tone_reg <= ~tone_reg;
  end

  assign tone_pin_out     = tone_reg & tone_on;
  assign tone_pin_oe_out  = tone_on;
  assign gpio_disable_out = tone_on;
  assign timeout_out      = timeout_reg;

  // ==========================================================
  // read port, data one cycle after strobe; reload reads zero
  always_ff @(posedge mclk_in)
  begin
    if (!resetn_in)
      rdata_reg <= 8'h00;
    else if (rd_in)
    begin
      case (addr_in)
        tmr0_pkg::ADDR_COUNT: rdata_reg <= count_reg;
        tmr0_pkg::ADDR_MODE:  rdata_reg <= mode_reg;
        tmr0_pkg::ADDR_FLAGS: rdata_reg <= flags_reg;
        default:              rdata_reg <= 8'h00;
      endcase
    end
    else
      rdata_reg <= 8'h00;
  end

  assign rdata_out = rdata_reg;
endmodule
`default_nettype wire

// ===== tmr0_checker.sv
// port-level checker of the timer 0 block
// bound onto tmr0_top; sees its ports only
`timescale 1ns/1ps
`default_nettype none
module tmr0_checker (
  input wire logic       mclk_in,
  input wire logic       resetn_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic       wr_in,
  input wire logic       rd_in,
  input wire logic [7:0] rdata_out,
  input wire logic       timeout_out,
  input wire logic       tone_pin_out,
  input wire logic       tone_pin_oe_out,
  input wire logic       gpio_disable_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);
  // ==========================================================
  // pin and tone
  chk_gpio_follows_oe: assert property (gpio_disable_out == tone_pin_oe_out)
    else $error("gpio disable differs from tone enable");
  chk_tone_low_off: assert property (!tone_pin_oe_out |-> !tone_pin_out)
    else $error("tone pin driven while disabled");
  chk_tone_on_timeout: assert property ($changed(tone_pin_out) && $stable(tone_pin_oe_out) |-> ##[0:1] timeout_out)
    else $error("tone toggled without time-out");
  chk_oe_from_mode: assert property (wr_in && addr_in == tmr0_pkg::ADDR_MODE |=>
    tone_pin_oe_out == ($past(wdata_in[1]) && !$past(wdata_in[0])))
    else $error("tone enable not taken from mode write");
  // ==========================================================
  // register port
  chk_rdata_idle: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
    else $error("read data outside read answer");
  chk_reload_write_only: assert property (rd_in && addr_in == tmr0_pkg::ADDR_RELOAD |=> rdata_out == 8'h00)
    else $error("reload register readable");
  chk_flags_other_zero: assert property (rd_in && addr_in == tmr0_pkg::ADDR_FLAGS |=> (rdata_out & 8'hFB) == 8'h00)
    else $error("flags bits outside fast select read set");
  chk_unmapped_zero: assert property (rd_in && !(addr_in inside {8'hD8, 8'hDA, 8'hDB, 8'hCD}) |=> rdata_out == 8'h00)
    else $error("unmapped read returned data");
  cov_timeout: cover property (timeout_out);
  cov_tone_timeout: cover property (tone_pin_oe_out && timeout_out);
  cov_count_read: cover property (rd_in && addr_in == tmr0_pkg::ADDR_COUNT);
endmodule
bind tmr0_top tmr0_checker u_chk (.mclk_in(mclk_in), .resetn_in(resetn_in), .addr_in(addr_in),
  .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
  .timeout_out(timeout_out), .tone_pin_out(tone_pin_out), .tone_pin_oe_out(tone_pin_oe_out),
  .gpio_disable_out(gpio_disable_out));
`default_nettype wire

// ===== testbench.sv
// self-checking bench for the timer 0 block
// assumes tmr0_top with its plain register port
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin tests_run++; if ((s) !== (e)) begin fail_count++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, s); end end
module testbench;
  logic       mclk_in = 1'b0;
  logic       resetn_in = 1'b0;
  logic [7:0] addr_in = 8'h00;
  logic [7:0] wdata_in = 8'h00;
  logic       wr_in = 1'b0;
  logic       rd_in = 1'b0;
  logic [7:0] rdata_out;
  logic       timeout_out;
  logic       tone_pin_out;
  logic       tone_pin_oe_out;
  logic       gpio_disable_out;
  int         fail_count = 0;
  int         tests_run = 0;
  int         n;
  logic [7:0] d;
  logic       t;
  logic [7:0] amap [5] = '{8'hDB, 8'hDA, 8'hD8, 8'hCD, 8'h00};
  always #20 mclk_in = ~mclk_in;
  tmr0_top #(.CPU_DIV(1)) dut (.mclk_in(mclk_in), .resetn_in(resetn_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .timeout_out(timeout_out), .tone_pin_out(tone_pin_out),
    .tone_pin_oe_out(tone_pin_oe_out), .gpio_disable_out(gpio_disable_out));
  // ==========================================================
  // register port and timing tasks
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk_in);
    addr_in  <= a;
    wdata_in <= v;
    wr_in    <= 1'b1;
    @(posedge mclk_in);
    wr_in    <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge mclk_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge mclk_in);
    rd_in   <= 1'b0;
    @(negedge mclk_in);
    v = rdata_out;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    rd(a, d);
    `CHK("rdata", e, d)
  endtask
  task automatic wait_to(output int k);
    k = 0;
    do
    begin
      @(negedge mclk_in);
      k++;
    end
    while (timeout_out !== 1'b1 && k < 9000);
    if (k >= 9000)
    begin
      fail_count++;
      end_of_test();
    end
  endtask
  // cycles between time-outs, after two to settle
  task automatic per(input int e);
    wait_to(n);
    wait_to(n);
    wait_to(n);
    `CHK("period", e, n)
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ==========================================================
  // main sequence
  initial
  begin
    repeat (3) @(posedge mclk_in);
    resetn_in <= 1'b1;
    foreach (amap[i]) rdchk(amap[i], 8'h00);
    wr(tmr0_pkg::ADDR_COUNT, 8'hA5);
    rdchk(tmr0_pkg::ADDR_COUNT, 8'hA5);
    wr(tmr0_pkg::ADDR_RELOAD, 8'h5A);
    rdchk(tmr0_pkg::ADDR_RELOAD, 8'h00);
    wr(tmr0_pkg::ADDR_MODE, 8'h0E);
    rdchk(tmr0_pkg::ADDR_MODE, 8'h06);
    wr(tmr0_pkg::ADDR_FLAGS, 8'hFF);
    rdchk(tmr0_pkg::ADDR_FLAGS, 8'h04);
    $display("done: register access");
    wr(tmr0_pkg::ADDR_RELOAD, 8'hF0);
    for (int f = 0; f < 2; f++)
    begin
      wr(tmr0_pkg::ADDR_FLAGS, 8'(f << 2));
      for (int r = 0; r < 8; r++)
      begin
        wr(tmr0_pkg::ADDR_MODE, {1'h1, 3'(r), 4'h4});
        wr(tmr0_pkg::ADDR_COUNT, 8'hF0);
        per(16 << (8 - r - f));
      end
    end
    $display("done: prescaler and reload");
    wr(tmr0_pkg::ADDR_MODE, 8'hF0);
    per(256);
    wr(tmr0_pkg::ADDR_MODE, 8'hF6);
    per(16);
    `CHK("oe", 1'h1, tone_pin_oe_out)
    `CHK("gpio", 1'h1, gpio_disable_out)
    t = tone_pin_out;
    wait_to(n);
    `CHK("tone", ~t, tone_pin_out)
    wr(tmr0_pkg::ADDR_RELOAD, 8'h70);
    wr(tmr0_pkg::ADDR_MODE, 8'hF1);
    per(144);
    wr(tmr0_pkg::ADDR_MODE, 8'hF7);
    per(16);
    `CHK("oe", 1'h0, tone_pin_oe_out)
    $display("done: pwm and tone");
    wr(tmr0_pkg::ADDR_MODE, 8'h70);
    rd(tmr0_pkg::ADDR_COUNT, d);
    repeat (20) @(posedge mclk_in);
    rdchk(tmr0_pkg::ADDR_COUNT, d);
    $display("done: stop");
    end_of_test();
  end
endmodule
`default_nettype wire
